// ==== src/prs_pkg.sv ====
package prs_pkg;

    localparam int unsigned CLK_PERIOD_NS = 10;

    // Host-side reset timing
    localparam int unsigned POR_HOLD_NS   = 1000;
    localparam int unsigned BUS_TAIL_NS   = 100;
    localparam int unsigned BUS_HOLD_NS   = 1000;

    // Least times round up to whole cycles
    localparam int unsigned POR_HOLD_CYC  = (POR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BUS_TAIL_CYC  = (BUS_TAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BUS_HOLD_CYC  = (BUS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int unsigned CNT_W         = 16;

    // Device register layout and reset values
    localparam int unsigned DATA_W        = 8;
    localparam logic [7:0]  CFG_RST       = 8'h00;
    localparam logic        PME_EN_RST    = 1'b0;
    localparam logic        PME_STS_RST   = 1'b0;
    localparam logic        DRIVE_RST     = 1'b0;

    typedef enum logic [1:0] {
        HS_BOOT,
        HS_BUS_TAIL,
        HS_RUN,
        HS_BUS_RST
    } prs_host_state_type;

endpackage

// ==== src/prs_if.sv ====
interface prs_if #(
    parameter int unsigned W = prs_pkg::DATA_W
);
    // Reset and suspend lines from the host
    logic           por_n;
    logic           brst_n;
    logic           suspend;
    // Wake line, open drain, driven low while pme_oe is high
    logic           pme_oe;
    logic           pme_n;
    // Device output buffers
    logic [W-1:0]   dev_data;
    logic           dev_oe;
    // Wire levels seen by the host; undriven bus reads as pulled high
    logic [W-1:0]   bus_data;

    assign pme_n    = ~pme_oe;
    assign bus_data = dev_oe ? dev_data : {W{1'b1}};

    modport device (
        input  por_n,
        input  brst_n,
        input  suspend,
        output pme_oe,
        output dev_data,
        output dev_oe
    );

    modport host (
        output por_n,
        output brst_n,
        output suspend,
        input  pme_n,
        input  dev_oe,
        input  bus_data
    );
endinterface

// ==== src/prs_rst_sync.sv ====
module prs_rst_sync (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    output wire logic srst_n_o
);
    logic stage1_q;
    logic stage2_q;

    // Assert at once, release on the second rising edge
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
        end else begin
            stage1_q <= 1'b1;
            stage2_q <= stage1_q;
        end
    end

    assign srst_n_o = stage2_q;
endmodule

// ==== src/prs_device.sv ====
// How it works
// - Power-on reset: outputs off, registers cleared
// - Unprotected power-on reset also clears wake context
// - With wake support, host uses power-on reset at boot only
// - Host holds bus reset across every reset
// - Without wake support, both resets tied together
// - Suspend keeps registers through power-on reset
// - Everything samples on the clock rising edge
// - Bus reset: core registers cleared, wake context kept, outputs off
// - Wake line only driven when enabled
// - After bus reset, default configuration, ready
// - Suspend keeps registers through bus reset
module prs_device
    import prs_pkg::*;
#(
    parameter int unsigned W = DATA_W
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rstn_i,
    prs_if.device             link,
    input  wire logic         cfg_wr_i,
    input  wire logic [W-1:0] cfg_wdata_i,
    input  wire logic         out_en_wr_i,
    input  wire logic         out_en_i,
    input  wire logic         pme_en_wr_i,
    input  wire logic         pme_en_i,
    input  wire logic         wake_event_i,
    input  wire logic         pme_clr_i,
    output logic [W-1:0]      cfg_o,
    output logic              pme_en_o,
    output logic              pme_sts_o,
    output logic              ready_o,
    output logic              in_reset_o
);

    // Reset gating and the synchronised copies
    logic         por_gate_n;
    logic         core_gate_n;
    logic         por_sync_n;
    logic         core_sync_n;
    logic         resets_free;
    logic [1:0]   sync_arst_n;
    logic [1:0]   sync_n;

    // Register state
    logic [W-1:0] cfg_q;
    logic [W-1:0] cfg_d;
    logic         drive_q;
    logic         drive_d;
    logic [W-1:0] out_q;
    logic [W-1:0] out_d;

    logic         pme_en_q;
    logic         pme_en_d;
    logic         pme_sts_q;
    logic         pme_sts_d;

    logic         in_reset_q;
    logic         in_reset_d;
    logic         ready_q;
    logic         ready_d;

    // A reset line reaches the registers unless suspend protects them
    function automatic logic gate_reset(input logic line_n, input logic protect);
        return line_n | protect;
    endfunction

    // Suspend masks the reset from the registers; outputs still go off
    // Suspend must be steady while either reset is low to avoid glitches
    assign por_gate_n  = gate_reset(link.por_n, link.suspend);
    assign core_gate_n = por_gate_n & gate_reset(link.brst_n, link.suspend);

    // Index 0 guards the wake context, index 1 the core registers
    assign sync_arst_n[0] = por_gate_n & rstn_i;
    assign sync_arst_n[1] = core_gate_n & rstn_i;

    for (genvar g = 0; g < 2; g++) begin : g_sync
        prs_rst_sync u_prs_rst_sync (
            .clk_i    (clk_sys_i),
            .arst_n_i (sync_arst_n[g]),
            .srst_n_o (sync_n[g])
        );
    end

    assign por_sync_n  = sync_n[0];
    assign core_sync_n = sync_n[1];

    assign resets_free = link.por_n & link.brst_n;

    // Configuration word, cleared by either unprotected reset
    always_comb begin
        cfg_d = cfg_q;
        if (cfg_wr_i) begin
            cfg_d = cfg_wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge core_sync_n) begin
        if (!core_sync_n) begin
            cfg_q <= W'(CFG_RST);
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // Output buffer enable, off again after every unprotected reset
    always_comb begin
        drive_d = drive_q;
        if (out_en_wr_i) begin
            drive_d = out_en_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge core_sync_n) begin
        if (!core_sync_n) begin
            drive_q <= DRIVE_RST;
        end else begin
            drive_q <= drive_d;
        end
    end

    // Output data stage, one cycle behind the configuration word
    always_comb begin
        out_d = cfg_q;
    end

    always_ff @(posedge clk_sys_i or negedge core_sync_n) begin
        if (!core_sync_n) begin
            out_q <= W'(CFG_RST);
        end else begin
            out_q <= out_d;
        end
    end

    // Wake enable survives bus reset, cleared only by power-on reset or rstn_i
    always_comb begin
        pme_en_d = pme_en_q;
        if (pme_en_wr_i) begin
            pme_en_d = pme_en_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge por_sync_n) begin
        if (!por_sync_n) begin
            pme_en_q <= PME_EN_RST;
        end else begin
            pme_en_q <= pme_en_d;
        end
    end

    // Wake status; an event in the clearing cycle wins
    always_comb begin
        pme_sts_d = pme_sts_q;
        if (pme_clr_i) begin
            pme_sts_d = 1'b0;
        end
        if (wake_event_i) begin
            pme_sts_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge por_sync_n) begin
        if (!por_sync_n) begin
            pme_sts_q <= PME_STS_RST;
        end else begin
            pme_sts_q <= pme_sts_d;
        end
    end

    // Reset flag for the user side, one cycle behind the lines
    always_comb begin
        in_reset_d = ~resets_free;
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            in_reset_q <= 1'b1;
        end else begin
            in_reset_q <= in_reset_d;
        end
    end

    // Ready once both lines are free and the core reset has left sync
    always_comb begin
        ready_d = resets_free & core_sync_n;
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= ready_d;
        end
    end

    // Output buffers go off the moment either reset line falls
    assign link.dev_data = out_q;
    assign link.dev_oe   = drive_q & resets_free & rstn_i;

    // Wake line may be driven in bus reset, only when enabled,
    // but never while power-on reset is low, protected or not
    assign link.pme_oe   = pme_en_q & pme_sts_q & link.por_n & rstn_i;

    assign cfg_o      = cfg_q;
    assign pme_en_o   = pme_en_q;
    assign pme_sts_o  = pme_sts_q;
    assign ready_o    = ready_q;
    assign in_reset_o = in_reset_q;

endmodule

// ==== src/prs_host.sv ====
module prs_host
    import prs_pkg::*;
#(
    parameter bit          WAKE_SUPPORT = 1'b1,
    parameter int unsigned W            = DATA_W
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rstn_i,
    prs_if.host               link,
    input  wire logic         bus_reset_req_i,
    input  wire logic         suspend_i,
    output logic              busy_o,
    output logic              wake_seen_o,
    output logic [W-1:0]      bus_data_o,
    output logic              bus_valid_o
);

    prs_host_state_type state_q;
    prs_host_state_type state_d;
    logic [CNT_W-1:0]   cnt_q;
    logic [CNT_W-1:0]   cnt_d;
    logic               por_n_q;
    logic               por_n_d;
    logic               brst_n_q;
    logic               brst_n_d;
    logic               wake_q;
    logic               wake_d;
    logic [W-1:0]       data_q;
    logic [W-1:0]       data_d;
    logic               valid_q;
    logic               valid_d;

    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q + 1'b1;
        por_n_d  = por_n_q;
        brst_n_d = brst_n_q;
        unique case (state_q)
            HS_BOOT: begin
                por_n_d  = 1'b0;
                brst_n_d = 1'b0;
                if (cnt_q == CNT_W'(POR_HOLD_CYC - 1)) begin
                    por_n_d = 1'b1;
                    cnt_d   = '0;
                    state_d = HS_BUS_TAIL;
                end
            end
            HS_BUS_TAIL: begin
                if (cnt_q == CNT_W'(BUS_TAIL_CYC - 1)) begin
                    brst_n_d = 1'b1;
                    cnt_d    = '0;
                    state_d  = HS_RUN;
                end
            end
            HS_RUN: begin
                cnt_d = '0;
                if (bus_reset_req_i) begin
                    brst_n_d = 1'b0;
                    state_d  = HS_BUS_RST;
                end
            end
            HS_BUS_RST: begin
                if (cnt_q == CNT_W'(BUS_HOLD_CYC - 1)) begin
                    brst_n_d = 1'b1;
                    cnt_d    = '0;
                    state_d  = HS_RUN;
                end
            end
        endcase
    end

    // Sample the link only on the rising edge
    always_comb begin
        wake_d  = ~link.pme_n;
        data_d  = link.bus_data;
        valid_d = link.dev_oe;
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q  <= HS_BOOT;
            cnt_q    <= '0;
            por_n_q  <= 1'b0;
            brst_n_q <= 1'b0;
            wake_q   <= 1'b0;
            data_q   <= '0;
            valid_q  <= 1'b0;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            por_n_q  <= por_n_d;
            brst_n_q <= brst_n_d;
            wake_q   <= wake_d;
            data_q   <= data_d;
            valid_q  <= valid_d;
        end
    end

    assign link.brst_n  = brst_n_q;
    assign link.por_n   = WAKE_SUPPORT ? por_n_q : brst_n_q;
    assign link.suspend = suspend_i;

    assign busy_o      = (state_q != HS_RUN);
    assign wake_seen_o = wake_q;
    assign bus_data_o  = data_q;
    assign bus_valid_o = valid_q;

endmodule

// ==== verification/prs_chk_sva.sv ====
module prs_chk
    import prs_pkg::*;
#(
    parameter int unsigned W = DATA_W
) (
    input wire logic         clk_sys_i,
    input wire logic         rstn_i,
    input wire logic         por_n,
    input wire logic         brst_n,
    input wire logic         suspend,
    input wire logic         pme_oe,
    input wire logic [W-1:0] dev_data,
    input wire logic         dev_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);

    a_por_outs_off: assert property (!por_n |-> !dev_oe)
        else $error("outputs on in power-on reset");
    a_por_no_wake: assert property (!por_n |-> !pme_oe)
        else $error("wake line on in power-on reset");
    a_por_once: assert property (!$fell(por_n))
        else $error("power-on reset after boot");
    a_boot_tail: assert property ($rose(por_n) |-> !brst_n [*8])
        else $error("bus reset tail too short");
    a_brst_outs_off: assert property (!brst_n |-> !dev_oe)
        else $error("outputs on in bus reset");
    a_brst_clear: assert property (!brst_n && !suspend |-> dev_data == '0)
        else $error("output data kept in bus reset");
    a_susp_keep: assert property (!brst_n && !$past(brst_n) && suspend && $past(suspend)
        |-> $stable(dev_data))
        else $error("data changed in protected reset");
    a_rel_default: assert property ($rose(brst_n) && !suspend
        |-> (!dev_oe && dev_data == '0) [*3])
        else $error("not default after release");

    c_wake_in_reset: cover property (pme_oe && !brst_n);
    c_susp_reset: cover property ($fell(brst_n) && suspend);
    c_drive_on: cover property ($rose(dev_oe));
endmodule

// ==== verification/pci_reset_suspend_control_bench.sv ====
module pci_reset_suspend_control_bench
    import prs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {logic [7:0] d; logic oe; logic [7:0] bus;} prs_row_type;
    prs_row_type rows [4] = '{'{8'hA5, 1'b1, 8'hA5}, '{8'h3C, 1'b0, 8'hFF},
                              '{8'h00, 1'b1, 8'h00}, '{8'hFF, 1'b1, 8'hFF}};
    logic       clk_sys_i = 1'b0;
    logic       rstn_i = 1'b0;
    logic       cfg_wr_i = 1'b0, out_en_wr_i = 1'b0, out_en_i = 1'b0;
    logic [7:0] cfg_wdata_i = 8'h00;
    logic       pme_en_wr_i = 1'b0, pme_en_i = 1'b0, wake_event_i = 1'b0;
    logic       pme_clr_i = 1'b0, bus_reset_req_i = 1'b0, suspend_i = 1'b0;
    logic [7:0] cfg_o, bus_data_o;
    logic       pme_en_o, pme_sts_o, ready_o, in_reset_o;
    logic       busy_o, wake_seen_o, bus_valid_o;
    logic [7:0] cfg_b, bus_data_b;
    logic       pme_sts_b, bus_valid_b;
    int         n_fail = 0, n_checks = 0;

    always #5 clk_sys_i = ~clk_sys_i;

    prs_if u_prs_if ();
    prs_device u_prs_device (.clk_sys_i, .rstn_i, .link(u_prs_if.device), .cfg_wr_i,
        .cfg_wdata_i, .out_en_wr_i, .out_en_i, .pme_en_wr_i, .pme_en_i, .wake_event_i,
        .pme_clr_i, .cfg_o, .pme_en_o, .pme_sts_o, .ready_o, .in_reset_o);
    prs_host u_prs_host (.clk_sys_i, .rstn_i, .link(u_prs_if.host), .bus_reset_req_i,
        .suspend_i, .busy_o, .wake_seen_o, .bus_data_o, .bus_valid_o);
    prs_chk u_prs_chk (.clk_sys_i, .rstn_i, .por_n(u_prs_if.por_n),
        .brst_n(u_prs_if.brst_n), .suspend(u_prs_if.suspend), .pme_oe(u_prs_if.pme_oe),
        .dev_data(u_prs_if.dev_data), .dev_oe(u_prs_if.dev_oe));

    // Second pair: no wake support, power-on reset follows bus reset
    prs_if u_prs_if_b ();
    prs_device u_prs_device_b (.clk_sys_i, .rstn_i, .link(u_prs_if_b.device), .cfg_wr_i,
        .cfg_wdata_i, .out_en_wr_i, .out_en_i, .pme_en_wr_i, .pme_en_i, .wake_event_i,
        .pme_clr_i, .cfg_o(cfg_b), .pme_en_o(), .pme_sts_o(pme_sts_b), .ready_o(),
        .in_reset_o());
    prs_host #(.WAKE_SUPPORT(1'b0)) u_prs_host_b (.clk_sys_i, .rstn_i, .link(u_prs_if_b.host),
        .bus_reset_req_i, .suspend_i, .busy_o(), .wake_seen_o(), .bus_data_o(bus_data_b),
        .bus_valid_o(bus_valid_b));

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic tick(input int n = 1);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wait_rdy();
        int i;
        for (i = 0; i < 400 && !(ready_o === 1'b1 && busy_o === 1'b0); i++) tick();
        if (i == 400) begin
            n_fail++;
            $display("ERROR %0t ready never came", $time);
            test_done();
        end
    endtask
    task automatic wr(input logic [7:0] d, input logic oe);
        cfg_wr_i = 1'b1;
        cfg_wdata_i = d;
        out_en_wr_i = 1'b1;
        out_en_i = oe;
        tick();
        cfg_wr_i = 1'b0;
        out_en_wr_i = 1'b0;
        tick(3);
    endtask
    task automatic wake(input logic en, input logic ev, input logic clr);
        pme_en_wr_i = 1'b1;
        pme_en_i = en;
        wake_event_i = ev;
        pme_clr_i = clr;
        tick();
        pme_en_wr_i = 1'b0;
        wake_event_i = 1'b0;
        pme_clr_i = 1'b0;
        tick(3);
    endtask
    task automatic brq();
        bus_reset_req_i = 1'b1;
        tick();
        bus_reset_req_i = 1'b0;
        tick(2);
    endtask

    initial begin
        tick(3);
        chk_b(u_prs_if.dev_oe, 1'b0);
        chk_b(in_reset_o, 1'b1);
        rstn_i = 1'b1;
        wait_rdy();
        chk_v(cfg_o, CFG_RST);
        chk_b(pme_sts_o, PME_STS_RST);
        chk_b(in_reset_o, 1'b0);
        $display("test reset done");
        for (int r = 0; r < 4; r++) begin
            wr(rows[r].d, rows[r].oe);
            chk_v(cfg_o, rows[r].d);
            chk_v(bus_data_o, rows[r].bus);
            chk_b(bus_valid_o, rows[r].oe);
        end
        $display("test rows done");
        wr(8'hA5, 1'b1);
        wake(1'b1, 1'b1, 1'b0);
        chk_b(pme_en_o, 1'b1);
        chk_b(wake_seen_o, 1'b1);
        brq();
        chk_b(bus_valid_o, 1'b0);
        chk_v(bus_data_o, 8'hFF);
        chk_b(wake_seen_o, 1'b1);
        chk_b(in_reset_o, 1'b1);
        chk_b(busy_o, 1'b1);
        chk_b(u_prs_if.por_n, 1'b1);
        chk_b(u_prs_if_b.por_n, 1'b0);
        wait_rdy();
        tick(2);
        chk_v(cfg_o, CFG_RST);
        chk_b(bus_valid_o, 1'b0);
        chk_b(pme_sts_o, 1'b1);
        chk_b(pme_sts_b, 1'b0);
        wake(1'b1, 1'b0, 1'b1);
        chk_b(wake_seen_o, 1'b0);
        wake(1'b0, 1'b1, 1'b0);
        chk_b(pme_sts_o, 1'b1);
        chk_b(wake_seen_o, 1'b0);
        brq();
        chk_b(wake_seen_o, 1'b0);
        wait_rdy();
        $display("test bus reset done");
        wr(8'h5A, 1'b1);
        suspend_i = 1'b1;
        brq();
        chk_b(bus_valid_o, 1'b0);
        chk_b(bus_valid_b, 1'b0);
        wait_rdy();
        tick();
        suspend_i = 1'b0;
        tick(3);
        chk_v(cfg_o, 8'h5A);
        chk_v(bus_data_o, 8'h5A);
        chk_v(cfg_b, 8'h5A);
        chk_v(bus_data_b, 8'h5A);
        $display("test suspend done");
        rstn_i = 1'b0;
        tick();
        chk_b(u_prs_if.dev_oe, 1'b0);
        rstn_i = 1'b1;
        wait_rdy();
        chk_b(pme_sts_o, 1'b0);
        chk_v(cfg_o, CFG_RST);
        $display("test second reset done");
        test_done();
    end
endmodule
